// [verilog/pmw_pkg.sv]
//------------------------------------------------------------
// power mode and wakeup control package
//------------------------------------------------------------
// Summary of operation
// - sleep in active with software standby set enters standby or watch mode
// - sleep in subactive with software standby set enters watch mode, or active on a direct transition
// - standby clear: active sleeps to sleep mode (subactive on a direct transition), subactive to subsleep
// - noise sample rate select: 0 gives osc/16, 1 gives osc/4
// - direct transition from subactive to active high or medium speed
// - edge select bits: 0 falling, 1 rising; shared inputs follow
// - interrupt enables pass timer A and direct-transition flags to cpu
// - timer A flag sets when the 8-bit counter wraps to zero
// - request flags clear only by written 0; writing 1 does nothing
// - direct-transition flag sets when a direct transition really occurs
// - wakeup flag sets on falling edge of a pin enabled for wakeup
// - wakeup flags reset to zero and clear only by written 0
// - serial interface standby bit: 0 holds standby, 1 releases
// - watchdog standby bit: 0 holds standby, 1 releases
// - event counter standby bit: 0 holds standby, 1 releases
package pmw_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] PMW_OFF_CTL1 = 8'h00; // standby, low speed, timer a clk
  localparam logic [7:0] PMW_OFF_CTL2 = 8'h04; // system_control_two
  localparam logic [7:0] PMW_OFF_EDGE = 8'h08; // irq edge selects
  localparam logic [7:0] PMW_OFF_IEN = 8'h0c; // interrupt enables
  localparam logic [7:0] PMW_OFF_IRR = 8'h10; // request flags
  localparam logic [7:0] PMW_OFF_WKF = 8'h14; // wakeup_request_flags
  localparam logic [7:0] PMW_OFF_WKEN = 8'h18; // wakeup pin selects
  localparam logic [7:0] PMW_OFF_MSTB = 8'h1c; // module standby controls
  localparam logic [7:0] PMW_OFF_MODE = 8'h20; // current mode, read only
  localparam logic [7:0] PMW_OFF_STAT = 8'h24; // interrupt status, read only
  localparam logic [7:0] PMW_OFF_ICLR = 8'h28; // interrupt clear, write only
  localparam logic [7:0] PMW_OFF_IMSK = 8'h2c; // interrupt mask

  // control one fields
  localparam int PMW_C1_SOFTWARE_STANDBY = 0;
  localparam int PMW_C1_LOW_SPEED_ON = 1;
  localparam int PMW_C1_TMA = 2;
  // control two fields
  localparam int PMW_C2_NSEL = 4;
  localparam int PMW_C2_DIRECT_TRANSITION_ON = 3;
  localparam int PMW_C2_MEDIUM_SPEED_ON = 2;
  localparam logic [7:0] PMW_CTL2_RST = 8'hf0;
  localparam logic [7:0] PMW_CTL2_RO = 8'he0; // upper bits read as one
  // request flag fields
  localparam int PMW_IRR_TA = 0;
  localparam int PMW_IRR_DT = 1;
  // module standby fields
  localparam int PMW_MS_SCI = 0;
  localparam int PMW_MS_WDT = 1;
  localparam int PMW_MS_AEC = 2;

  // noise sampler dividers
  localparam int PMW_NDIV_SLOW = 16;
  localparam int PMW_NDIV_FAST = 4;

  localparam int PMW_NIRQ = 4;
  localparam int PMW_NWKP = 8;
  localparam int PMW_NEVT = 14; // 2 request + 4 irq + 8 wakeup

  typedef enum {
    PMW_ACTIVE, PMW_ACTIVE_MED, PMW_SLEEP, PMW_SUBACTIVE, PMW_SUBSLEEP,
    PMW_STANDBY, PMW_WATCH
  } pmw_mode_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
  } pmw_ctl_t;

endpackage

// [verilog/pmw_edge.sv]
`timescale 1ns/1ps
// synchroniser plus selectable edge detector, one per pin
module pmw_edge
  import pmw_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  input wire logic [WIDTH-1:0] rise_sel,
  input wire logic sample_en,
  output logic [WIDTH-1:0] edge_pulse
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;

  //------------------------------------------------------------
  // per-pin logic
  //------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      // two flops first; the meta stage feeds only the sync stage
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else begin
          meta_q[g] <= pin[g];
          sync_q[g] <= meta_q[g];
        end
      end
      // last sample moves only on the noise clock, so a glitch shorter
      // than one sample period is still caught if a sample strobe lands inside it
      always_ff @(posedge clock) begin
        if (rst) begin
          last_q[g] <= 1'b1;
          edge_pulse[g] <= 1'b0;
        end else begin
          edge_pulse[g] <= 1'b0;
          if (sample_en) begin
            last_q[g] <= sync_q[g];
            edge_pulse[g] <= rise_sel[g] ? (sync_q[g] & ~last_q[g])
                                         : (~sync_q[g] & last_q[g]);
          end
        end
      end
    end
  endgenerate
endmodule

// [verilog/pmw_top.sv]
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// power mode transition control, wakeup flags and apb register file
module pmw_top
  import pmw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic timer_a_overflow,
  input wire logic [3:0] irq_pin,
  input wire logic timer_c_event_input,
  input wire logic timer_f_event_input,
  input wire logic converter_trigger_input,
  input wire logic [7:0] wakeup_pin,
  output logic [2:0] power_mode,
  output logic direct_transition_done,
  output logic timer_a_irq,
  output logic direct_transition_irq,
  output logic [3:0] irq_edge_event,
  output logic noise_sample_en,
  output logic serial_interface_one_standby,
  output logic watchdog_module_standby,
  output logic event_counter_standby,
  output logic irq
);

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic [3:0] edge_q;
  logic [1:0] ien_q;
  logic [1:0] irr_q;
  logic [7:0] wkf_q;
  logic [7:0] wken_q;
  logic [2:0] mstb_q;
  logic [PMW_NEVT-1:0] stat_q;
  logic [PMW_NEVT-1:0] imsk_q;
  pmw_mode_t mode_q;
  pmw_mode_t mode_d;
  logic dt_d;
  logic [3:0] ndiv_q;
  logic [3:0] irq_ev;
  logic [7:0] wk_ev;
  pmw_ctl_t view;

  logic wr;
  logic rd_ok;
  logic [31:0] wd;
  assign wr = psel & penable & pwrite & pready;
  assign wd = pwdata;
  assign view = '{mode: 3'(mode_q), ctl1: ctl1_q, ctl2: ctl2_q};

  //------------------------------------------------------------
  // apb handshake
  //------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // unmapped offsets answer with pslverr and read zero
  always_comb begin
    rd_ok = 1'b1;
    case (paddr)
      PMW_OFF_CTL1, PMW_OFF_CTL2, PMW_OFF_EDGE, PMW_OFF_IEN, PMW_OFF_IRR,
      PMW_OFF_WKF, PMW_OFF_WKEN, PMW_OFF_MSTB, PMW_OFF_MODE, PMW_OFF_STAT,
      PMW_OFF_ICLR, PMW_OFF_IMSK: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end

  // read data registered with the ready pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~rd_ok;
      prdata <= 32'h0;
      if (psel & penable & ~pready & ~pwrite) begin
        case (paddr)
          PMW_OFF_CTL1: prdata <= {24'h0, view.ctl1};
          PMW_OFF_CTL2: prdata <= {24'h0, view.ctl2 | PMW_CTL2_RO};
          PMW_OFF_EDGE: prdata <= {28'h0, edge_q};
          PMW_OFF_IEN: prdata <= {30'h0, ien_q};
          PMW_OFF_IRR: prdata <= {30'h0, irr_q};
          PMW_OFF_WKF: prdata <= {24'h0, wkf_q};
          PMW_OFF_WKEN: prdata <= {24'h0, wken_q};
          PMW_OFF_MSTB: prdata <= {29'h0, mstb_q};
          PMW_OFF_MODE: prdata <= {29'h0, view.mode};
          PMW_OFF_STAT: prdata <= {18'h0, stat_q};
          PMW_OFF_IMSK: prdata <= {18'h0, imsk_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // plain control registers
  //------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl1_q <= 8'h0;
      ctl2_q <= PMW_CTL2_RST;
      edge_q <= 4'h0;
      ien_q <= 2'h0;
      wken_q <= 8'h0;
      mstb_q <= 3'h0;
      imsk_q <= '0;
    end else if (wr) begin
      case (paddr)
        PMW_OFF_CTL1: ctl1_q <= wd[7:0];
        PMW_OFF_CTL2: ctl2_q <= wd[7:0] | PMW_CTL2_RO;
        PMW_OFF_EDGE: edge_q <= wd[3:0];
        PMW_OFF_IEN: ien_q <= wd[1:0];
        PMW_OFF_WKEN: wken_q <= wd[7:0];
        PMW_OFF_MSTB: mstb_q <= wd[2:0];
        PMW_OFF_IMSK: imsk_q <= wd[PMW_NEVT-1:0];
        default: ;
      endcase
    end
  end

  //------------------------------------------------------------
  // sleep transition decision
  //------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    dt_d = 1'b0;
    if (sleep_exec) begin
      case (mode_q)
        PMW_ACTIVE, PMW_ACTIVE_MED: begin
          // direct drop to subactive skips the sleep mode round trip
          if (ctl2_q[PMW_C2_DIRECT_TRANSITION_ON] && !ctl1_q[PMW_C1_SOFTWARE_STANDBY] && ctl1_q[PMW_C1_TMA]
              && ctl1_q[PMW_C1_LOW_SPEED_ON]) begin
            mode_d = PMW_SUBACTIVE;
            dt_d = 1'b1;
          end else if (!ctl1_q[PMW_C1_SOFTWARE_STANDBY]) begin
            mode_d = PMW_SLEEP;
          end else if (ctl1_q[PMW_C1_TMA]) begin
            mode_d = PMW_WATCH;
          end else begin
            mode_d = PMW_STANDBY;
          end
        end
        PMW_SUBACTIVE: begin
          if (ctl2_q[PMW_C2_DIRECT_TRANSITION_ON] && ctl1_q[PMW_C1_SOFTWARE_STANDBY] && ctl1_q[PMW_C1_TMA]
              && !ctl1_q[PMW_C1_LOW_SPEED_ON]) begin
            mode_d = ctl2_q[PMW_C2_MEDIUM_SPEED_ON] ? PMW_ACTIVE_MED : PMW_ACTIVE;
            dt_d = 1'b1;
          end else if (ctl1_q[PMW_C1_SOFTWARE_STANDBY]) begin
            mode_d = PMW_WATCH;
          end else begin
            mode_d = PMW_SUBSLEEP;
          end
        end
        default: mode_d = mode_q;
      endcase
    end else begin
      // any wakeup event returns a low power mode to its running mode
      case (mode_q)
        PMW_SLEEP, PMW_STANDBY: begin
          if (|wk_ev || |irq_ev) begin
            mode_d = ctl2_q[PMW_C2_MEDIUM_SPEED_ON] ? PMW_ACTIVE_MED : PMW_ACTIVE;
          end
        end
        PMW_SUBSLEEP, PMW_WATCH: begin
          if (|wk_ev || |irq_ev) begin
            mode_d = ctl1_q[PMW_C1_LOW_SPEED_ON] ? PMW_SUBACTIVE : PMW_ACTIVE;
          end
        end
        default: mode_d = mode_q;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= PMW_ACTIVE;
      direct_transition_done <= 1'b0;
    end else begin
      mode_q <= mode_d;
      direct_transition_done <= dt_d;
    end
  end

  //------------------------------------------------------------
  // noise sampler divider
  //------------------------------------------------------------
  // the divider restarts at the shorter period so a select change
  // takes effect within one sample
  always_ff @(posedge clock) begin
    if (rst) begin
      ndiv_q <= 4'h0;
      noise_sample_en <= 1'b0;
    end else begin
      if (ctl2_q[PMW_C2_NSEL]) begin
        ndiv_q <= (ndiv_q >= 4'(PMW_NDIV_FAST - 1)) ? 4'h0 : ndiv_q + 4'h1;
        noise_sample_en <= (ndiv_q >= 4'(PMW_NDIV_FAST - 1));
      end else begin
        ndiv_q <= (ndiv_q == 4'(PMW_NDIV_SLOW - 1)) ? 4'h0 : ndiv_q + 4'h1;
        noise_sample_en <= (ndiv_q == 4'(PMW_NDIV_SLOW - 1));
      end
    end
  end

  //------------------------------------------------------------
  // pin edge detectors
  //------------------------------------------------------------
  // irq1 and irq3 share their pin with timer c / f, irq4 with the trigger
  pmw_edge #(.WIDTH(PMW_NIRQ)) u_irq_edge (
    .clock(clock),
    .rst(rst),
    .pin({converter_trigger_input & irq_pin[3], timer_f_event_input & irq_pin[2],
          irq_pin[1], timer_c_event_input & irq_pin[0]}),
    .rise_sel(edge_q),
    .sample_en(noise_sample_en),
    .edge_pulse(irq_ev)
  );

  pmw_edge #(.WIDTH(PMW_NWKP)) u_wk_edge (
    .clock(clock),
    .rst(rst),
    .pin(wakeup_pin),
    .rise_sel(8'h00),
    .sample_en(noise_sample_en),
    .edge_pulse(wk_ev)
  );

  //------------------------------------------------------------
  // request flags: set wins over a same-cycle written 0
  //------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      irr_q <= 2'h0;
    end else begin
      if (wr && paddr == PMW_OFF_IRR) begin
        irr_q <= irr_q & wd[1:0];
      end
      if (timer_a_overflow) begin
        irr_q[PMW_IRR_TA] <= 1'b1;
      end
      if (dt_d) begin
        irr_q[PMW_IRR_DT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wkf_q <= 8'h0;
    end else begin
      wkf_q <= ((wr && paddr == PMW_OFF_WKF) ? (wkf_q & wd[7:0]) : wkf_q)
               | (wk_ev & wken_q);
    end
  end

  //------------------------------------------------------------
  // outputs and sticky interrupt status
  //------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_a_irq <= 1'b0;
      direct_transition_irq <= 1'b0;
      irq_edge_event <= 4'h0;
      power_mode <= 3'h0;
      serial_interface_one_standby <= 1'b1;
      watchdog_module_standby <= 1'b1;
      event_counter_standby <= 1'b1;
    end else begin
      timer_a_irq <= irr_q[PMW_IRR_TA] & ien_q[PMW_IRR_TA];
      direct_transition_irq <= irr_q[PMW_IRR_DT] & ien_q[PMW_IRR_DT];
      irq_edge_event <= irq_ev;
      power_mode <= 3'(mode_q);
      serial_interface_one_standby <= ~mstb_q[PMW_MS_SCI];
      watchdog_module_standby <= ~mstb_q[PMW_MS_WDT];
      event_counter_standby <= ~mstb_q[PMW_MS_AEC];
    end
  end

  // status bit order: wakeup[13:6], irq edges[5:2], dt, timer a
  always_ff @(posedge clock) begin
    if (rst) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      stat_q <= ((wr && paddr == PMW_OFF_ICLR) ? (stat_q & ~wd[PMW_NEVT-1:0]) : stat_q)
                | {wk_ev & wken_q, irq_ev, dt_d, timer_a_overflow};
      irq <= |(stat_q & imsk_q);
    end
  end

endmodule

// [testbench/pmw_chk.sv]
`timescale 1ns/1ps
// ------
// port checker for the power mode block
// ------
module pmw_chk
  import pmw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sleep_exec,
  input wire logic timer_a_overflow,
  input wire logic [2:0] power_mode,
  input wire logic direct_transition_done,
  input wire logic timer_a_irq,
  input wire logic noise_sample_en,
  input wire logic serial_interface_one_standby,
  input wire logic watchdog_module_standby,
  input wire logic event_counter_standby
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] ie_q;
  logic [7:0] ms_q;
  logic wr;

  // shadows take only accepted writes, so they move on the design's own edge
  assign wr = psel && penable && pwrite && pready;
  always_ff @(posedge clock) begin
    if (rst) begin
      c1_q <= 8'h00;
      c2_q <= 8'hf0;
      ie_q <= 8'h00;
      ms_q <= 8'h00;
    end else if (wr) begin
      if (paddr == PMW_OFF_CTL1) c1_q <= pwdata[7:0];
      if (paddr == PMW_OFF_CTL2) c2_q <= pwdata[7:0];
      if (paddr == PMW_OFF_IEN) ie_q <= pwdata[7:0];
      if (paddr == PMW_OFF_MSTB) ms_q <= pwdata[7:0];
    end
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_sleep_plain: assert property (
    power_mode == 3'h0 && sleep_exec && !c1_q[0] && !c2_q[3] |-> ##[2:3] power_mode == 3'h2)
    else $error("active sleep did not reach sleep mode");
  a_standby_pick: assert property (
    power_mode == 3'h0 && sleep_exec && c1_q[0] && !c2_q[3]
    |-> ##[2:3] power_mode == (c1_q[2] ? 3'h6 : 3'h5)) else $error("standby entry wrong");
  a_sub_sleep: assert property (
    power_mode == 3'h3 && sleep_exec && !c2_q[3]
    |-> ##[2:3] power_mode == (c1_q[0] ? 3'h6 : 3'h4)) else $error("subactive sleep wrong");
  a_direct_up: assert property (
    power_mode == 3'h3 && sleep_exec && c2_q[3] && c1_q[2:0] == 3'h5
    |-> ##[2:3] power_mode == {2'h0, c2_q[2]}) else $error("direct target wrong");
  a_dt_cause: assert property (
    direct_transition_done |-> c2_q[3] && ($past(sleep_exec) || $past(sleep_exec, 2)))
    else $error("direct transition without sleep");
  a_ta_pass: assert property (timer_a_overflow && ie_q[0] |-> ##[1:3] timer_a_irq)
    else $error("timer a request missing");
  a_ta_block: assert property (!ie_q[0] && !$past(ie_q[0]) |-> !timer_a_irq)
    else $error("timer a request not blocked");
  a_sample_gap: assert property (noise_sample_en |=> !noise_sample_en [*3])
    else $error("sample strobes too close");
  a_sample_fast: assert property (
    $past(noise_sample_en, 4) && c2_q[4] && $past(c2_q[4], 5) |-> noise_sample_en)
    else $error("fast sample rate wrong");
  a_standby_bits: assert property ($stable(ms_q) |->
    {serial_interface_one_standby, watchdog_module_standby, event_counter_standby}
    == ~{ms_q[0], ms_q[1], ms_q[2]}) else $error("module standby output wrong");
endmodule

bind pmw_top pmw_chk u_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .sleep_exec, .timer_a_overflow, .power_mode, .direct_transition_done,
  .timer_a_irq, .noise_sample_en, .serial_interface_one_standby,
  .watchdog_module_standby, .event_counter_standby);

// [testbench/pmw_cpu.sv]
`timescale 1ns/1ps
// ------
// cpu side: apb master and sleep strobe
// ------
module pmw_cpu (
  input wire logic clock,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic sleep_exec
);
  initial begin
    {psel, penable, pwrite, sleep_exec} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // request held until pready is seen; only the bench timeout ends a stall
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d; // released bus must not keep showing the old word
  endtask

  task automatic sleep();
    @(posedge clock);
    sleep_exec <= 1'b1;
    @(posedge clock);
    sleep_exec <= 1'b0;
  endtask

  // clear only flags already seen set; ones elsewhere must leave flags alone
  task automatic clr(input logic [7:0] a, input logic [7:0] m);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    if ((r[7:0] & m) != 8'h00) xfer(1'b1, a, ~{24'h0, r[7:0] & m}, r, e);
  endtask
endmodule

// [testbench/power_mode_and_wakeup_control_test.sv]
`timescale 1ns/1ps
// ------
// bench for the power mode and wakeup block
// ------
module power_mode_and_wakeup_control_test
  import pmw_pkg::*;
;
  typedef struct packed {logic r; logic [7:0] c1; logic [7:0] c2; logic [2:0] m;} pmw_row_t;
  logic clock = 1'b0, rst = 1'b1, ta = 1'b0, tc = 1'b1, tf = 1'b1, adt = 1'b1;
  logic psel, penable, pwrite, sleep_exec, pready, pslverr, er, dtd, dt_irq, irq;
  logic ta_irq, nse, s_sci, s_wdt, s_aec;
  logic [3:0] irq_pin = 4'hf, iev;
  logic [7:0] paddr, wkp = 8'hff;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] power_mode;
  int bad_count = 0, n_tests = 0, cyc = 0, ns = 0, evs = 0, e0;
  // reset flag, control one, control two, mode expected after sleep
  pmw_row_t rows [11] = '{'{1'h1, 8'h00, 8'h00, 3'h2}, '{1'h1, 8'h01, 8'h00, 3'h5},
    '{1'h1, 8'h05, 8'h00, 3'h6}, '{1'h1, 8'h06, 8'h08, 3'h3}, '{1'h0, 8'h05, 8'h08, 3'h0},
    '{1'h0, 8'h06, 8'h08, 3'h3}, '{1'h0, 8'h05, 8'h0c, 3'h1}, '{1'h1, 8'h06, 8'h08, 3'h3},
    '{1'h0, 8'h01, 8'h00, 3'h6}, '{1'h1, 8'h06, 8'h08, 3'h3}, '{1'h0, 8'h02, 8'h00, 3'h4}};

  pmw_top dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_exec, .timer_a_overflow(ta), .irq_pin, .timer_c_event_input(tc),
    .timer_f_event_input(tf), .converter_trigger_input(adt), .wakeup_pin(wkp),
    .power_mode, .direct_transition_done(dtd), .timer_a_irq(ta_irq),
    .direct_transition_irq(dt_irq), .irq_edge_event(iev), .noise_sample_en(nse),
    .serial_interface_one_standby(s_sci), .watchdog_module_standby(s_wdt),
    .event_counter_standby(s_aec), .irq);
  pmw_cpu cpu (.clock, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata, .sleep_exec);

  initial begin
    forever #5 clock = ~clock;
  end

  // counts land by nba, so snapshots taken at an edge never race them
  always @(posedge clock) begin
    cyc <= cyc + 1;
    ns <= ns + 32'(nse);
    evs <= evs + 32'({iev[3], 3'h0, iev[2], 3'h0, iev[1], 3'h0, iev[0]});
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, rd, er);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    cpu.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
  endtask

  task automatic rst_on(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic ovf();
    @(posedge clock);
    ta <= 1'b1;
    @(posedge clock);
    ta <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst_on(10);
    foreach (rows[i]) begin
      if (rows[i].r) rst_on(2);
      wr(PMW_OFF_CTL1, 32'(rows[i].c1));
      wr(PMW_OFF_CTL2, 32'(rows[i].c2));
      cpu.sleep();
      repeat (4) @(posedge clock);
      chk(32'(power_mode), 32'(rows[i].m));
      if (rows[i].m < 3'h2) begin
        rc(PMW_OFF_IRR, 32'h2);
        wr(PMW_OFF_IEN, 32'h2);
        repeat (2) @(posedge clock);
        chk(32'(dt_irq), 32'h1);
        cpu.clr(PMW_OFF_IRR, 8'h02);
        rc(PMW_OFF_IRR, 32'h0);
        chk(32'(dt_irq), 32'h0);
      end
    end
    $display("test done: mode table");
    // reset from subsleep in mid-run must restore every default
    rst_on(2);
    chk(32'({s_sci, s_wdt, s_aec}), 32'h7);
    for (int i = 0; i < 10; i++) rc(8'(i * 4), i == 1 ? 32'hf0 : 32'h0);
    cpu.xfer(1'b0, 8'h30, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1);
    wr(PMW_OFF_CTL2, 32'h1f);
    rc(PMW_OFF_CTL2, 32'hff);
    $display("test done: reset and map");
    wr(PMW_OFF_IEN, 32'h1);
    wr(PMW_OFF_IMSK, 32'h1);
    ovf();
    chk(32'({ta_irq, irq}), 32'h3);
    wr(PMW_OFF_IRR, 32'hff);
    rc(PMW_OFF_IRR, 32'h1);
    cpu.clr(PMW_OFF_IRR, 8'h01);
    wr(PMW_OFF_ICLR, 32'h1);
    repeat (3) @(posedge clock);
    chk(32'({ta_irq, irq}), 32'h0);
    wr(PMW_OFF_IEN, 32'h0);
    ovf();
    chk(32'({ta_irq, irq}), 32'h1);
    rc(PMW_OFF_IRR, 32'h1);
    $display("test done: timer a");
    wr(PMW_OFF_CTL2, 32'h00);
    e0 = ns;
    repeat (64) @(posedge clock);
    chk(32'(ns - e0), 32'h4);
    wr(PMW_OFF_CTL2, 32'h10);
    e0 = ns;
    repeat (64) @(posedge clock);
    chk(32'(ns - e0), 32'h10);
    // pin one rises only; the shared inputs pull their pins low
    wr(PMW_OFF_EDGE, 32'h2);
    wr(PMW_OFF_WKEN, 32'h8);
    e0 = evs;
    for (int k = 0; k < 2; k++) begin
      irq_pin <= k ? 4'hf : 4'hd;
      {tc, tf, adt} <= k ? 3'h7 : 3'h0;
      wkp <= k ? 8'hff : 8'hd7;
      repeat (40) @(posedge clock);
      chk(32'(evs - e0), k ? 32'h1111 : 32'h1101);
    end
    rc(PMW_OFF_WKF, 32'h8);
    cpu.clr(PMW_OFF_WKF, 8'h08);
    rc(PMW_OFF_WKF, 32'h0);
    $display("test done: pins");
    wr(PMW_OFF_MSTB, 32'h5);
    repeat (2) @(posedge clock);
    chk(32'({s_sci, s_wdt, s_aec}), 32'h2);
    $display("test done: module standby");
    conclude();
  end
endmodule
